// file: common/vas_pkg.sv
`default_nettype none
package vas_pkg;
	localparam int          LANE_W          = 32;
	localparam int          REG_ADDR_W      = 8;
	// Instruction fields, bit 0 of the printed layout is instr[31]
	localparam logic [5:0]  OPC_PRIMARY     = 6'h04;
	localparam logic [4:0]  FIELD_ZERO      = 5'h00;
	localparam logic [10:0] XO_SUB_SMOD     = 11'h4cb;
	localparam logic [10:0] XO_SUB_SSAT     = 11'h4c3;
	localparam logic [10:0] XO_SUB_USAT     = 11'h4c2;
	localparam logic [10:0] XO_SUB_UMOD     = 11'h4ca;
	localparam logic [10:0] XO_MOVE_ACC     = 11'h4c4;
	localparam logic [10:0] XO_MAC_UNS      = 11'h558;
	// Saturation values per lane
	localparam logic [31:0] SAT_POS         = 32'h7fffffff;
	localparam logic [31:0] SAT_NEG         = 32'h80000000;
	localparam logic [31:0] SAT_UNS_FLOOR   = 32'h00000000;
	// Register map, byte addresses
	localparam logic [7:0]  REG_STATUS      = 8'h00;
	localparam logic [7:0]  REG_EVENT       = 8'h04;
	localparam logic [7:0]  REG_MASK        = 8'h08;
	localparam logic [7:0]  REG_ACC_HI      = 8'h0c;
	localparam logic [7:0]  REG_ACC_LO      = 8'h10;
	// Status fields
	localparam int          ST_SAT_LO       = 0;
	localparam int          ST_SAT_HI       = 1;
	localparam int          ST_STICKY_LO    = 2;
	localparam int          ST_STICKY_HI    = 3;
	localparam int          ST_BIG_ENDIAN   = 8;
	localparam logic        BIG_ENDIAN_RST  = 1'b1;
	// Event fields
	localparam int          EV_SAT_LO       = 0;
	localparam int          EV_SAT_HI       = 1;
	localparam int          EV_ALIGN        = 2;
	localparam int          EV_W            = 3;
	localparam logic [2:0]  MASK_RST        = 3'h0;

	typedef enum logic [1:0] {MK_LOAD_DD, MK_LOAD_DW, MK_STORE, MK_SCALAR} vas_mem_kind_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] instr;
		logic [63:0] src_a;
		logic [63:0] src_b;
	} vas_issue_t;

	typedef struct packed {
		logic        valid;
		logic [63:0] data;
	} vas_result_t;

	typedef struct packed {
		logic          valid;
		vas_mem_kind_t kind;
		logic          indexed;
		logic [4:0]    base_field;
		logic [63:0]   base;
		logic [63:0]   index;
		logic [31:0]   disp;
	} vas_mem_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] ea;
		logic        fault;
		logic [63:0] data;
	} vas_mem_resp_t;
endpackage
`default_nettype wire

// file: core/vas_acc_unit.sv
// Chosen here: the register offsets and the plain strobed port.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Modulo subtracts write lanes to result and accumulator
// - Decode signed saturating subtract opcode
// - Signed saturation clamps to max or min
// - Per-lane flags set, sticky flags accumulate
// - Decode unsigned saturating subtract opcode
// - Unsigned borrow clamps lane to zero
// - Unsigned borrow reported through same flags
// - Decode unsigned modulo subtract, flags untouched
// - Move copies source into accumulator and result
// - Base field zero selects base zero
// - Address uses low 32 bits only
// - Scalar load keeps destination upper half
// - Unaligned double-word access raises alignment fault; only ea[1:0] is checked, so a word-aligned access does not fault
// - Little-endian word load reverses each word
// - Indexed address is base plus index
// - Multiply-accumulate adds 64-bit product, keeps 64
module vas_acc_unit
	import vas_pkg::*;
#(
	parameter int ADDR_W = REG_ADDR_W
)(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire vas_issue_t        issue,
	input  wire vas_mem_req_t      mem_req,
	input  wire logic [63:0]       mem_rdata,
	input  wire logic [63:0]       dest_old,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	output var vas_result_t        result,
	output var vas_mem_resp_t      mem_resp,
	output logic                   irq
);
	generate
		if (ADDR_W < 5) begin : g_chk
			$error("ADDR_W too small for register map");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Decode

	logic          common_ok;
	logic          op_smod;
	logic          op_ssat;
	logic          op_usat;
	logic          op_umod;
	logic          op_move;
	logic          op_mac;
	logic          sub_op;
	logic          sat_op;
	logic          signed_op;

	assign common_ok = issue.valid && (issue.instr[31:26] == OPC_PRIMARY);
	assign op_smod   = common_ok && (issue.instr[15:11] == FIELD_ZERO) && (issue.instr[10:0] == XO_SUB_SMOD);
	assign op_ssat   = common_ok && (issue.instr[15:11] == FIELD_ZERO) && (issue.instr[10:0] == XO_SUB_SSAT);
	assign op_usat   = common_ok && (issue.instr[15:11] == FIELD_ZERO) && (issue.instr[10:0] == XO_SUB_USAT);
	assign op_umod   = common_ok && (issue.instr[15:11] == FIELD_ZERO) && (issue.instr[10:0] == XO_SUB_UMOD);
	assign op_move   = common_ok && (issue.instr[15:11] == FIELD_ZERO) && (issue.instr[10:0] == XO_MOVE_ACC);
	assign op_mac    = common_ok && (issue.instr[10:0] == XO_MAC_UNS);
	assign sub_op    = op_smod | op_ssat | op_usat | op_umod;
	assign sat_op    = op_ssat | op_usat;
	assign signed_op = op_smod | op_ssat;

	////////////////////////////////////////////////////////////////////////////
	// Datapath

	logic [63:0]  acc;
	logic [63:0]  sub_res;
	logic [1:0]   lane_sat;
	logic [63:0]  product;
	logic [64:0]  mac_sum;
	logic [63:0]  op_value;
	logic         op_hit;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_lane
			vas_lane_sub u_lane (
				.acc_lane  (acc[LANE_W*i +: LANE_W]),
				.a_lane    (issue.src_a[LANE_W*i +: LANE_W]),
				.signed_op (signed_op),
				.sat_op    (sat_op),
				.res       (sub_res[LANE_W*i +: LANE_W]),
				.sat       (lane_sat[i])
			);
		end
	endgenerate

	assign product  = {32'h0, issue.src_a[31:0]} * {32'h0, issue.src_b[31:0]};
	assign mac_sum  = {1'b0, acc} + {1'b0, product};
	// Zero operands leave the total unchanged, which is how software reads it
	assign op_value = op_move ? issue.src_a : (op_mac ? mac_sum[63:0] : sub_res);
	assign op_hit   = sub_op | op_move | op_mac;

	// Whole 64-bit word written at once, never one lane alone
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc <= 64'h0;
		end else if (op_hit) begin
			acc <= op_value;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			result <= '0;
		end else begin
			result.valid <= op_hit;
			result.data  <= op_hit ? op_value : 64'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Load and store addressing

	logic [31:0]   ea;
	logic          misaligned;
	logic [63:0]   load_data;
	logic          big_endian;

	vas_agen u_agen (
		.req        (mem_req),
		.mem_rdata  (mem_rdata),
		.dest_old   (dest_old),
		.big_endian (big_endian),
		.ea         (ea),
		.misaligned (misaligned),
		.load_data  (load_data)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_resp <= '0;
		end else begin
			mem_resp.valid <= mem_req.valid;
			mem_resp.ea    <= ea;
			mem_resp.fault <= mem_req.valid & misaligned;
			// A faulting load completes nothing, so the old value is returned
			mem_resp.data  <= (mem_req.valid && !misaligned) ? load_data : dest_old;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic          sat_lo;
	logic          sat_hi;
	logic          sticky_lo;
	logic          sticky_hi;
	logic [EV_W-1:0] evt;
	logic [EV_W-1:0] mask;
	logic          wr_status;
	logic          wr_event;
	logic          wr_mask;
	logic          next_sat_lo;
	logic          next_sat_hi;
	logic          next_sticky_lo;
	logic          next_sticky_hi;
	logic          next_big_endian;
	logic [EV_W-1:0] evt_set;
	logic [EV_W-1:0] next_evt;
	logic [31:0]   status_word;
	logic [31:0]   read_mux;

	assign wr_status       = reg_wr && (reg_addr == ADDR_W'(REG_STATUS));
	assign wr_event        = reg_wr && (reg_addr == ADDR_W'(REG_EVENT));
	assign wr_mask         = reg_wr && (reg_addr == ADDR_W'(REG_MASK));

	// Hardware update wins over a software write in the same cycle
	assign next_sat_lo     = sat_op ? lane_sat[0] : (wr_status ? reg_wdata[ST_SAT_LO] : sat_lo);
	assign next_sat_hi     = sat_op ? lane_sat[1] : (wr_status ? reg_wdata[ST_SAT_HI] : sat_hi);
	assign next_sticky_lo  = (wr_status ? reg_wdata[ST_STICKY_LO] : sticky_lo) | (sat_op & lane_sat[0]);
	assign next_sticky_hi  = (wr_status ? reg_wdata[ST_STICKY_HI] : sticky_hi) | (sat_op & lane_sat[1]);
	assign next_big_endian = wr_status ? reg_wdata[ST_BIG_ENDIAN] : big_endian;

	assign evt_set[EV_SAT_LO] = sat_op & lane_sat[0];
	assign evt_set[EV_SAT_HI] = sat_op & lane_sat[1];
	assign evt_set[EV_ALIGN]  = mem_req.valid & misaligned;
	assign next_evt        = (evt & ~(wr_event ? reg_wdata[EV_W-1:0] : {EV_W{1'b0}})) | evt_set;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sat_lo     <= 1'b0;
			sat_hi     <= 1'b0;
			sticky_lo  <= 1'b0;
			sticky_hi  <= 1'b0;
			big_endian <= BIG_ENDIAN_RST;
		end else begin
			sat_lo     <= next_sat_lo;
			sat_hi     <= next_sat_hi;
			sticky_lo  <= next_sticky_lo;
			sticky_hi  <= next_sticky_hi;
			big_endian <= next_big_endian;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			evt  <= '0;
			mask <= MASK_RST;
		end else begin
			evt  <= next_evt;
			mask <= wr_mask ? reg_wdata[EV_W-1:0] : mask;
		end
	end

	always_comb begin
		status_word                = 32'h0;
		status_word[ST_SAT_LO]     = sat_lo;
		status_word[ST_SAT_HI]     = sat_hi;
		status_word[ST_STICKY_LO]  = sticky_lo;
		status_word[ST_STICKY_HI]  = sticky_hi;
		status_word[ST_BIG_ENDIAN] = big_endian;
	end

	always_comb begin
		case (reg_addr)
			ADDR_W'(REG_STATUS): read_mux = status_word;
			ADDR_W'(REG_EVENT):  read_mux = {{(32-EV_W){1'b0}}, evt};
			ADDR_W'(REG_MASK):   read_mux = {{(32-EV_W){1'b0}}, mask};
			ADDR_W'(REG_ACC_HI): read_mux = acc[63:32];
			ADDR_W'(REG_ACC_LO): read_mux = acc[31:0];
			default:             read_mux = 32'h0;
		endcase
	end

	// Data valid only in the cycle after the strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_rd ? read_mux : 32'h0;
		end
	end

	assign irq = |(evt & mask);

	////////////////////////////////////////////////////////////////////////////
	// Checks

	// Wrapped low-lane difference, an independent overflow reference
	logic [31:0]   lo_wrap;
	assign lo_wrap = acc[31:0] - issue.src_a[31:0];

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_mod_sub_lanes: assert property (
		(op_smod || op_umod) |=> (result.data[31:0] == $past(acc[31:0]) - $past(issue.src_a[31:0]))
			&& (result.data[63:32] == $past(acc[63:32]) - $past(issue.src_a[63:32])) && (acc == result.data))
		else $error("modulo subtract result wrong");

	a_ssat_decode: assert property (
		(issue.valid && {issue.instr[31:26], issue.instr[15:0]} == {OPC_PRIMARY, FIELD_ZERO, XO_SUB_SSAT})
			|-> op_ssat && sat_op)
		else $error("signed saturating subtract not decoded");

	a_ssat_clamp: assert property (
		(op_ssat && lane_sat[1]) |=> (result.data[63:32] == SAT_POS || result.data[63:32] == SAT_NEG)
			&& (acc[63:32] == result.data[63:32]))
		else $error("signed saturation value wrong");

	a_sat_sticky: assert property (
		(sat_op && !reg_wr) |=> (sat_lo == $past(lane_sat[0])) && (sat_hi == $past(lane_sat[1]))
			&& (sticky_lo == ($past(sticky_lo) | $past(lane_sat[0]))))
		else $error("saturation flags not updated");

	a_usat_decode: assert property (
		(issue.valid && {issue.instr[31:26], issue.instr[15:0]} == {OPC_PRIMARY, FIELD_ZERO, XO_SUB_USAT})
			|-> op_usat && !signed_op)
		else $error("unsigned saturating subtract not decoded");

	a_usat_floor: assert property (
		(op_usat && issue.src_a[31:0] > acc[31:0]) |=> (result.data[31:0] == SAT_UNS_FLOOR) && sat_lo)
		else $error("unsigned borrow not clamped or flagged");

	a_umod_flags: assert property (
		(op_umod && !reg_wr) |=> $stable(sat_lo) && $stable(sat_hi) && $stable(sticky_hi))
		else $error("modulo subtract changed flags");

	a_move_acc: assert property (
		op_move |=> (acc == $past(issue.src_a)) && (result.data == $past(issue.src_a)) && result.valid)
		else $error("move to accumulator wrong");

	a_base_zero: assert property (
		(mem_req.valid && mem_req.indexed && mem_req.base_field == FIELD_ZERO)
			|=> (mem_resp.ea == $past(mem_req.index[31:0])))
		else $error("zero base field not honoured");

	a_scalar_upper: assert property (
		(mem_req.valid && mem_req.kind == MK_SCALAR) |=> (mem_resp.data[63:32] == $past(dest_old[63:32])))
		else $error("scalar load touched upper half");

	a_align_fault: assert property (
		(mem_req.valid && mem_req.kind != MK_SCALAR) |=> (mem_resp.fault == (mem_resp.ea[1:0] != 2'h0))
			&& (evt[EV_ALIGN] || !mem_resp.fault))
		else $error("alignment fault wrong");

	a_le_words: assert property (
		(mem_req.valid && mem_req.kind == MK_LOAD_DW && !big_endian && !misaligned)
			|=> (mem_resp.data[63:56] == $past(mem_rdata[39:32])) && (mem_resp.data[31:24] == $past(mem_rdata[7:0])))
		else $error("little-endian word placement wrong");

	a_mac_sum: assert property (
		op_mac |=> (acc == $past(acc) + ($past(issue.src_a[31:0]) * $past(issue.src_b[31:0]))))
		else $error("multiply-accumulate sum wrong");

	a_ssat_lo_clamp: assert property (
		(op_ssat && lane_sat[0]) |=> (result.data[31:0] == SAT_POS || result.data[31:0] == SAT_NEG)
			&& (acc[31:0] == result.data[31:0]))
		else $error("signed low lane saturation value wrong");

	a_signed_over: assert property (
		op_ssat |-> (lane_sat[0] == ((acc[31] != issue.src_a[31]) && (lo_wrap[31] != acc[31]))))
		else $error("signed overflow detection wrong");

	a_usat_hi_flag: assert property (
		op_usat |=> (sat_hi == ($past(issue.src_a[63:32]) > $past(acc[63:32]))) && (sticky_hi || !sat_hi))
		else $error("unsigned upper borrow not flagged");

	a_indexed_ea: assert property (
		(mem_req.valid && mem_req.indexed && mem_req.base_field != FIELD_ZERO)
			|=> (mem_resp.ea == $past(mem_req.base[31:0]) + $past(mem_req.index[31:0])))
		else $error("indexed address wrong");

	a_disp_ea: assert property (
		(mem_req.valid && !mem_req.indexed && mem_req.base_field != FIELD_ZERO)
			|=> (mem_resp.ea == $past(mem_req.base[31:0]) + $past(mem_req.disp)))
		else $error("displacement address wrong");

	a_lanes_commit: assert property (
		sub_op |=> (acc == result.data) && result.valid)
		else $error("lanes not committed together");

	a_align_event: assert property (
		(mem_req.valid && misaligned) |=> evt[EV_ALIGN] && mem_resp.fault)
		else $error("alignment event not raised");
endmodule // vas_acc_unit
`default_nettype wire

// file: core/vas_agen.sv
`default_nettype none
module vas_agen
	import vas_pkg::*;
(
	input  wire vas_mem_req_t req,
	input  wire logic [63:0]  mem_rdata,
	input  wire logic [63:0]  dest_old,
	input  wire logic         big_endian,
	output logic [31:0]       ea,
	output logic              misaligned,
	output logic [63:0]       load_data
);
	logic [31:0] base_eff;
	logic [31:0] offset;
	logic [63:0] words_le;
	logic [63:0] dword_le;
	logic        dword_op;

	assign base_eff   = (req.base_field == FIELD_ZERO) ? 32'h00000000 : req.base[31:0];
	assign offset     = req.indexed ? req.index[31:0] : req.disp;
	assign ea         = base_eff + offset;
	assign dword_op   = (req.kind != MK_SCALAR);
	assign misaligned = dword_op & (ea[1:0] != 2'h0);

	generate
		for (genvar b = 0; b < 8; b++) begin : g_swap
			assign words_le[8*b +: 8] = mem_rdata[8*((b & 4) + 3 - (b & 3)) +: 8];
			assign dword_le[8*b +: 8] = mem_rdata[8*(7 - b) +: 8];
		end
	endgenerate

	always_comb begin
		case (req.kind)
			MK_LOAD_DW: load_data = big_endian ? mem_rdata : words_le;
			MK_LOAD_DD: load_data = big_endian ? mem_rdata : dword_le;
			MK_SCALAR:  load_data = {dest_old[63:32], mem_rdata[31:0]};
			default:    load_data = dest_old;
		endcase
	end
endmodule // vas_agen
`default_nettype wire

// file: core/vas_lane_sub.sv
`default_nettype none
module vas_lane_sub
	import vas_pkg::*;
(
	input  wire logic [LANE_W-1:0] acc_lane,
	input  wire logic [LANE_W-1:0] a_lane,
	input  wire logic              signed_op,
	input  wire logic              sat_op,
	output logic      [LANE_W-1:0] res,
	output logic                   sat
);
	logic [LANE_W:0]   ext_acc;
	logic [LANE_W:0]   ext_a;
	logic [LANE_W:0]   diff;
	logic              over;
	logic [LANE_W-1:0] sat_val;

	assign ext_acc = {signed_op & acc_lane[LANE_W-1], acc_lane};
	assign ext_a   = {signed_op & a_lane[LANE_W-1], a_lane};
	assign diff    = ext_acc - ext_a;
	// Top two bits disagree on signed overflow; top bit alone is the borrow
	assign over    = signed_op ? (diff[LANE_W] ^ diff[LANE_W-1]) : diff[LANE_W];
	assign sat     = sat_op & over;
	assign sat_val = signed_op ? (diff[LANE_W] ? SAT_NEG : SAT_POS) : SAT_UNS_FLOOR;
	assign res     = sat ? sat_val : diff[LANE_W-1:0];
endmodule // vas_lane_sub
`default_nettype wire

// file: tb/vas_issue_model.sv
`default_nettype none
module vas_issue_model
	import vas_pkg::*;
(
	input  wire logic       clock,
	output var  vas_issue_t issue
);
	timeunit 1ns;
	timeprecision 100ps;
	initial issue = '0;
	// One instruction per call, valid for exactly one cycle
	task automatic send(input logic [10:0] xo, input logic [63:0] a, input logic [63:0] b);
		logic [31:0] ins;
		ins = {OPC_PRIMARY, 5'h01, 5'h02, FIELD_ZERO, xo};
		@(posedge clock);
		issue <= '{valid: 1'b1, instr: ins, src_a: a, src_b: b};
		@(posedge clock);
		// Released fields show the inverse, never a stale match
		issue <= '{valid: 1'b0, instr: ~ins, src_a: ~a, src_b: ~b};
	endtask
	// Zero operands leave the total unchanged and copy it out
	task automatic read_acc();
		send(XO_MAC_UNS, 64'h0, 64'h0);
	endtask
endmodule // vas_issue_model
`default_nettype wire

// file: tb/vas_tb.sv
`default_nettype none
module tb
	import vas_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic          clock;
	logic          rst;
	vas_issue_t    issue;
	vas_mem_req_t  mem_req;
	logic [63:0]   mem_rdata;
	logic [63:0]   dest_old;
	logic [7:0]    reg_addr;
	logic [31:0]   reg_wdata;
	logic          reg_wr;
	logic          reg_rd;
	logic [31:0]   reg_rdata;
	vas_result_t   result;
	vas_mem_resp_t mem_resp;
	logic          irq;
	int            err_total;
	int            tests_run;
	vas_issue_model pm (.clock(clock), .issue(issue));
	vas_acc_unit dut (.clock(clock), .rst(rst), .issue(issue), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.dest_old(dest_old), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .result(result), .mem_resp(mem_resp), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic reg_check(input string nm, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(nm, {32'h0, exp}, {32'h0, reg_rdata});
	endtask
	task automatic do_op(input logic [10:0] xo, input logic [63:0] a, input logic [63:0] exp);
		pm.send(xo, a, 64'h0);
		#1 chk("result valid", 64'h1, {63'h0, result.valid});
		chk("result data", exp, result.data);
	endtask
	task automatic mem_op(input vas_mem_kind_t k, input logic ix, input logic [4:0] bf, input logic [63:0] b,
		input logic [63:0] i, input logic [31:0] d, input logic [31:0] ea, input logic flt, input logic [63:0] exp);
		@(posedge clock);
		mem_req <= '{valid: 1'b1, kind: k, indexed: ix, base_field: bf, base: b, index: i, disp: d};
		@(posedge clock);
		mem_req <= '{valid: 1'b0, kind: k, indexed: ~ix, base_field: ~bf, base: ~b, index: ~i, disp: ~d};
		#1 chk("mem valid", 64'h1, {63'h0, mem_resp.valid});
		chk("mem ea", {32'h0, ea}, {32'h0, mem_resp.ea});
		chk("mem fault", {63'h0, flt}, {63'h0, mem_resp.fault});
		chk("mem data", exp, mem_resp.data);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Reset state and an unmapped read
	task automatic t_reset();
		reg_check("status", REG_STATUS, 32'h00000100);
		reg_check("event", REG_EVENT, 32'h0);
		reg_check("mask", REG_MASK, 32'h0);
		reg_check("unmapped", 8'h40, 32'h0);
		chk("irq", 64'h0, {63'h0, irq});
	endtask
	// Load, then clamp both lanes in opposite directions
	task automatic t_signed_sat();
		do_op(XO_MOVE_ACC, 64'h7fffffff_80000000, 64'h7fffffff_80000000);
		do_op(XO_SUB_SSAT, 64'hffffffff_00000001, 64'h7fffffff_80000000);
		reg_check("status", REG_STATUS, 32'h0000010f);
		reg_check("event", REG_EVENT, 32'h3);
		chk("irq", 64'h0, {63'h0, irq});
		reg_write(REG_MASK, 32'h3);
		#1 chk("irq", 64'h1, {63'h0, irq});
		reg_check("mask", REG_MASK, 32'h00000003);
		reg_write(REG_EVENT, 32'h3);
		#1 chk("irq", 64'h0, {63'h0, irq});
	endtask
	// Borrow in one lane only; sticky bits survive, modulo ops keep flags
	task automatic t_unsigned_and_modulo();
		do_op(XO_SUB_USAT, 64'h00000001_90000000, 64'h7ffffffe_00000000);
		reg_check("status", REG_STATUS, 32'h0000010d);
		#1 chk("irq", 64'h1, {63'h0, irq});
		do_op(XO_SUB_UMOD, 64'h00000001_00000001, 64'h7ffffffd_ffffffff);
		do_op(XO_SUB_SMOD, 64'h80000000_00000002, 64'hfffffffd_fffffffd);
		reg_check("status", REG_STATUS, 32'h0000010d);
		reg_write(REG_EVENT, 32'h7);
	endtask
	// Accumulator read-back and a real multiply-accumulate
	task automatic t_acc_read();
		pm.read_acc();
		#1 chk("acc readback", 64'hfffffffd_fffffffd, result.data);
		pm.send(XO_MAC_UNS, 64'hffffffff_00000002, 64'h12345678_00000003);
		#1 chk("mac sum", 64'hfffffffe_00000003, result.data);
		reg_check("acc hi", REG_ACC_HI, 32'hfffffffe);
		reg_check("acc lo", REG_ACC_LO, 32'h00000003);
	endtask
	// Address forms, alignment fault, scalar merge, byte placement
	task automatic t_mem();
		@(posedge clock);
		mem_rdata <= 64'h01020304_05060708;
		dest_old <= 64'haaaabbbb_ccccdddd;
		mem_op(MK_LOAD_DW, 1'b0, 5'h3, 64'hffffffff_00000100, 64'h0, 32'h4, 32'h104, 1'b0, 64'h01020304_05060708);
		mem_op(MK_LOAD_DD, 1'b1, 5'h0, 64'h55, 64'habcd0000_00000200, 32'h0, 32'h200, 1'b0, 64'h01020304_05060708);
		mem_op(MK_LOAD_DD, 1'b1, 5'h4, 64'h100, 64'h2, 32'h0, 32'h102, 1'b1, 64'haaaabbbb_ccccdddd);
		reg_check("event", REG_EVENT, 32'h4);
		mem_op(MK_SCALAR, 1'b0, 5'h0, 64'h0, 64'h0, 32'h1, 32'h1, 1'b0, 64'haaaabbbb_05060708);
		reg_write(REG_STATUS, 32'h0000000d);
		mem_op(MK_LOAD_DW, 1'b0, 5'h0, 64'h0, 64'h0, 32'h8, 32'h8, 1'b0, 64'h04030201_08070605);
		mem_op(MK_LOAD_DD, 1'b0, 5'h0, 64'h0, 64'h0, 32'h10, 32'h10, 1'b0, 64'h08070605_04030201);
		mem_op(MK_STORE, 1'b0, 5'h0, 64'h0, 64'h0, 32'h6, 32'h6, 1'b1, 64'haaaabbbb_ccccdddd);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		report_and_stop();
	end
	initial begin
		err_total = 0;
		tests_run = 0;
		rst = 1'b1;
		mem_req = '0;
		mem_rdata = 64'h0;
		dest_old = 64'h0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_signed_sat();
		t_unsigned_and_modulo();
		t_acc_read();
		t_mem();
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
